/* File: rtl/cs_decode_defs.svh */
`ifndef CS_DECODE_DEFS_SVH
`define CS_DECODE_DEFS_SVH

// ------------------------------------------------------------
// Register offsets in the control block
// ------------------------------------------------------------
`define OFS_LOWER_AREA_LIMIT  8'ha2
`define OFS_PERIPH_BASE_REG   8'ha4
`define OFS_MIDRANGE_BASE_REG 8'ha6
`define OFS_MIDRANGE_SIZE_REG 8'ha8

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RDY_LSB        0
`define RDY_MSB        2
`define LOW_ONES_MSB   5
`define MID_BASE_LSB   9
`define MID_SIZE_LSB   8
`define MID_SIZE_MSB   14
`define PER_BASE_LSB   6
`define PER_SPACE_BIT  6
`define PER_LATCH_BIT  7
`define PER_WIN_SHIFT  7
`define PER_NUM        7
`define MID_NUM        4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CS_INACTIVE    1'b1
`define REG_RESET      16'h0000

`endif

/* File: rtl/cs_decode_pkg.sv */
package cs_decode_pkg;
	typedef logic [2:0]  ready_mode_t;
	typedef logic [15:0] ctl_word_t;
	typedef logic [19:0] addr_t;
	typedef enum logic [1:0] {
		RDY_SRC_NONE,
		RDY_SRC_LOW,
		RDY_SRC_MID,
		RDY_SRC_PER
	} ready_src_e;
endpackage

/* File: rtl/mid_range_match.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cs_decode_defs.svh"

module mid_range_match (
	input  wire logic [19:0] i_addr,
	input  wire logic [15:0] i_base,
	input  wire logic [15:0] i_size,
	output logic             o_hit,
	output logic      [1:0]  o_quarter
);
	// ------------------------------------------------------------
	// Block mask and quarter select
	// ------------------------------------------------------------
	logic [19:0] blk_mask;
	logic [19:0] base_addr;
	logic [1:0]  q;
	integer      k;

	assign base_addr = {i_base[15:`MID_BASE_LSB], 13'h0000}; // [R8]

	always_comb begin
		blk_mask = 20'h00000;
		q = 2'h0;
		for (k = 0; k < 7; k = k + 1) begin
			if (i_size[`MID_SIZE_LSB + k]) begin
				blk_mask = (20'h02000 << k) - 20'h00001;
				q = i_addr[12 + k -: 2]; // [R7]
			end
		end
	end

	assign o_hit     = (i_size[`MID_SIZE_MSB:`MID_SIZE_LSB] != 7'h00) &&
			   ((i_addr & ~blk_mask) == (base_addr & ~blk_mask)); // [R7]
	assign o_quarter = q;
endmodule
`default_nettype wire

/* File: rtl/periph_match.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cs_decode_defs.svh"

module periph_match (
	input  wire logic [19:0] i_addr,
	input  wire logic [15:0] i_base,
	output logic      [6:0]  o_win
);
	// ------------------------------------------------------------
	// Seven 128-byte windows above the 1K-aligned base
	// ------------------------------------------------------------
	logic       in_blk;
	logic [2:0] idx;

	assign in_blk = (i_addr[19:10] == i_base[15:`PER_BASE_LSB]); // [R15]
	assign idx    = i_addr[9:`PER_WIN_SHIFT];

	genvar n;
	generate
		for (n = 0; n < `PER_NUM; n = n + 1) begin : g_win
			assign o_win[n] = in_blk && (idx == 3'(n)); // [R14]
		end
	endgenerate
endmodule
`default_nettype wire

/* File: rtl/lower_mid_periph_chip_select.sv */
// Notes on behaviour
// R1: Low area always starts at address zero
// R2: Software writes only legal low-limit patterns
// R3: Low select when addr[19:4] <= limit|3f
// R4: Low select idle until limit register accessed
// R5: Low limit ready bits govern low area
// R6: Software sets exactly one mid size bit
// R7: Mid block split into four quarters
// R8: Mid base from bits 15:9 to A19:A13
// R9: Software aligns mid base to block size
// R10: Mid selects idle until base and size accessed
// R11: Mid base ready bits govern all quarters
// R12: Software avoids low area with 512K mid
// R13: Enhanced mode keeps only mid select two
// R14: Peripheral select n covers base plus n*128
// R15: Peripheral base bits 19:10 from register 15:6
// R16: Software zeroes base 15:12 in I/O space
// R17: Latch bit low gives A1/A2 on selects 5-6
// R18: Space bit picks memory or I/O for peripherals
// R19: Peripheral selects idle until both registers accessed (selects 5-6 still follow A1/A2 in latch mode, the reset setting)
// R20: Split ready bits for peripheral groups
// R21: Ready code gives waits and external-ready use
// R22: Selects high during reset
// R23: Selects respond to CPU and DMA cycles
// R24: Selects active low, matching space only
`timescale 1ns/1ps
`default_nettype none
`include "cs_decode_defs.svh"

module lower_mid_periph_chip_select (
	input  wire logic        I_MCLK,
	input  wire logic        I_ARST_N,
	input  wire logic        I_ENHANCED,
	input  wire logic [19:0] I_ADDR,
	input  wire logic        I_CYCLE,
	input  wire logic        I_CYCLE_MEM,
	input  wire logic        I_CYCLE_DMA,
	input  wire logic        I_REG_SEL,
	input  wire logic        I_REG_WR,
	input  wire logic        I_REG_RD,
	input  wire logic [7:0]  I_REG_OFS,
	input  wire logic [15:0] I_REG_WDATA,
	output logic      [15:0] O_REG_RDATA,
	output logic             O_LOW_MEMORY_SELECT_N,
	output logic      [3:0]  O_MID_RANGE_SELECTS_N,
	output logic      [6:0]  O_PERIPHERAL_SELECTS_N,
	output logic             O_AREA_HIT,
	output logic      [1:0]  O_WAIT_STATES,
	output logic             O_EXT_READY_USE
);
	// ------------------------------------------------------------
	// Control registers and access flags
	// ------------------------------------------------------------
	cs_decode_pkg::ctl_word_t lower_area_limit;
	cs_decode_pkg::ctl_word_t periph_base_reg;
	cs_decode_pkg::ctl_word_t midrange_base_reg;
	cs_decode_pkg::ctl_word_t midrange_size_reg;
	logic                     low_seen;
	logic                     pbase_seen;
	logic                     mbase_seen;
	logic                     msize_seen;
	logic                     acc;
	logic                     wr;

	assign acc = I_REG_SEL && (I_REG_WR || I_REG_RD);
	assign wr  = I_REG_SEL && I_REG_WR;

	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			lower_area_limit  <= `REG_RESET;
			periph_base_reg   <= `REG_RESET;
			midrange_base_reg <= `REG_RESET;
			midrange_size_reg <= `REG_RESET;
		end else if (wr) begin
			case (I_REG_OFS)
				`OFS_LOWER_AREA_LIMIT:  lower_area_limit  <= I_REG_WDATA;
				`OFS_PERIPH_BASE_REG:   periph_base_reg   <= I_REG_WDATA;
				`OFS_MIDRANGE_BASE_REG: midrange_base_reg <= I_REG_WDATA;
				`OFS_MIDRANGE_SIZE_REG: midrange_size_reg <= I_REG_WDATA;
				default: ;
			endcase
		end
	end

	// Any read or write counts as an access
	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			low_seen   <= 1'b0;
			pbase_seen <= 1'b0;
			mbase_seen <= 1'b0;
			msize_seen <= 1'b0;
		end else if (acc) begin
			if (I_REG_OFS == `OFS_LOWER_AREA_LIMIT)
				low_seen <= 1'b1; // [R4]
			if (I_REG_OFS == `OFS_PERIPH_BASE_REG)
				pbase_seen <= 1'b1; // [R19]
			if (I_REG_OFS == `OFS_MIDRANGE_BASE_REG)
				mbase_seen <= 1'b1; // [R10]
			if (I_REG_OFS == `OFS_MIDRANGE_SIZE_REG)
				msize_seen <= 1'b1;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_REG_RDATA <= 16'h0000;
		end else if (I_REG_SEL && I_REG_RD) begin
			case (I_REG_OFS)
				`OFS_LOWER_AREA_LIMIT:  O_REG_RDATA <= lower_area_limit;
				`OFS_PERIPH_BASE_REG:   O_REG_RDATA <= periph_base_reg;
				`OFS_MIDRANGE_BASE_REG: O_REG_RDATA <= midrange_base_reg;
				`OFS_MIDRANGE_SIZE_REG: O_REG_RDATA <= midrange_size_reg;
				default:                O_REG_RDATA <= 16'h0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Area decode
	// ------------------------------------------------------------
	logic       low_hit;
	logic       mid_hit;
	logic [1:0] mid_q;
	logic [6:0] per_win;
	logic       per_space_ok;
	logic       low_en;
	logic       mid_en;
	logic       per_en;
	logic       latch_mode;

	// Bottom fixed at zero, only the top compared
	assign low_hit = (I_ADDR[19:4] <= {lower_area_limit[15:6], 6'h3f}); // [R1] [R3]

	mid_range_match u_mid (
		.i_addr    (I_ADDR),
		.i_base    (midrange_base_reg),
		.i_size    (midrange_size_reg),
		.o_hit     (mid_hit),
		.o_quarter (mid_q)
	);

	periph_match u_per (
		.i_addr (I_ADDR),
		.i_base (periph_base_reg),
		.o_win  (per_win)
	);

	assign latch_mode   = !midrange_size_reg[`PER_LATCH_BIT]; // [R17]
	assign per_space_ok = (midrange_size_reg[`PER_SPACE_BIT] == I_CYCLE_MEM); // [R18] [R24]
	// DMA cycles decode exactly like CPU cycles
	assign low_en = I_CYCLE && I_CYCLE_MEM && low_seen; // [R23] [R24]
	assign mid_en = I_CYCLE && I_CYCLE_MEM && mbase_seen && msize_seen; // [R10] [R23]
	assign per_en = I_CYCLE && per_space_ok && pbase_seen && msize_seen; // [R19] [R23]

	// ------------------------------------------------------------
	// Select outputs, active low
	// ------------------------------------------------------------
	logic [3:0] next_mid_n;
	logic [6:0] next_per_n;

	always_comb begin
		next_mid_n = 4'hf;
		if (mid_en && mid_hit)
			next_mid_n[mid_q] = 1'b0; // [R7]
		if (I_ENHANCED) begin
			next_mid_n[0] = 1'b1; // [R13]
			next_mid_n[1] = 1'b1;
			next_mid_n[3] = 1'b1;
		end
	end

	always_comb begin
		next_per_n = ~(per_win & {7{per_en}}); // [R14]
		if (latch_mode) begin
			next_per_n[5] = I_ADDR[1]; // [R17]
			next_per_n[6] = I_ADDR[2];
		end
	end

	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_LOW_MEMORY_SELECT_N  <= `CS_INACTIVE; // [R22]
			O_MID_RANGE_SELECTS_N  <= 4'hf;
			O_PERIPHERAL_SELECTS_N <= 7'h7f;
		end else begin
			O_LOW_MEMORY_SELECT_N  <= !(low_en && low_hit); // [R4] [R24]
			O_MID_RANGE_SELECTS_N  <= next_mid_n;
			if (I_CYCLE || !latch_mode)
				O_PERIPHERAL_SELECTS_N <= next_per_n;
			else
				O_PERIPHERAL_SELECTS_N[4:0] <= 5'h1f;
		end
	end

	// ------------------------------------------------------------
	// Ready mode to the wait-state generator
	// ------------------------------------------------------------
	cs_decode_pkg::ready_mode_t next_mode;
	logic                       next_hit;

	always_comb begin
		next_mode = 3'h0;
		next_hit  = 1'b0;
		if (low_en && low_hit) begin
			next_mode = lower_area_limit[`RDY_MSB:`RDY_LSB]; // [R5]
			next_hit  = 1'b1;
		end else if (mid_en && mid_hit) begin
			next_mode = midrange_base_reg[`RDY_MSB:`RDY_LSB]; // [R11]
			next_hit  = 1'b1;
		end else if (per_en && (per_win[3:0] != 4'h0)) begin
			next_mode = periph_base_reg[`RDY_MSB:`RDY_LSB]; // [R20]
			next_hit  = 1'b1;
		end else if (per_en && (per_win[4] || (!latch_mode && per_win[6:5] != 2'h0))) begin
			next_mode = midrange_size_reg[`RDY_MSB:`RDY_LSB]; // [R20]
			next_hit  = 1'b1;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_AREA_HIT      <= 1'b0;
			O_WAIT_STATES   <= 2'h0;
			O_EXT_READY_USE <= 1'b0;
		end else begin
			O_AREA_HIT      <= next_hit;
			O_WAIT_STATES   <= next_mode[1:0]; // [R21]
			O_EXT_READY_USE <= next_hit && !next_mode[2]; // [R21]
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_low_idle;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		!low_seen |=> O_LOW_MEMORY_SELECT_N;
	endproperty
	a_low_idle: assert property (p_low_idle) else $error("low select before access"); // [R4]

	property p_low_hit;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		(low_seen && I_CYCLE && I_CYCLE_MEM && I_ADDR[19:4] <= {lower_area_limit[15:6], 6'h3f})
		|=> !O_LOW_MEMORY_SELECT_N;
	endproperty
	a_low_hit: assert property (p_low_hit) else $error("low select missed"); // [R3]

	property p_mid_idle;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		!(mbase_seen && msize_seen) |=> (O_MID_RANGE_SELECTS_N == 4'hf);
	endproperty
	a_mid_idle: assert property (p_mid_idle) else $error("mid select before access"); // [R10]

	property p_mid_onehot;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		$countones(~O_MID_RANGE_SELECTS_N) <= 1;
	endproperty
	a_mid_onehot: assert property (p_mid_onehot) else $error("two mid selects"); // [R7]

	property p_enh;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		I_ENHANCED |=> (O_MID_RANGE_SELECTS_N[1:0] == 2'h3) && O_MID_RANGE_SELECTS_N[3];
	endproperty
	a_enh: assert property (p_enh) else $error("handshake pin used as select"); // [R13]

	property p_per_idle;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		!(pbase_seen && msize_seen) && !latch_mode |=> (O_PERIPHERAL_SELECTS_N == 7'h7f);
	endproperty
	a_per_idle: assert property (p_per_idle) else $error("peripheral select early"); // [R19]

	sequence s_per0_cycle;
		per_en && (I_ADDR[19:7] == {periph_base_reg[15:6], 3'h0});
	endsequence
	property p_per0;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		s_per0_cycle |=> !O_PERIPHERAL_SELECTS_N[0];
	endproperty
	a_per0: assert property (p_per0) else $error("peripheral select 0 missed"); // [R14]

	property p_latch;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		(latch_mode && I_CYCLE) |=> (O_PERIPHERAL_SELECTS_N[6:5] == $past(I_ADDR[2:1]));
	endproperty
	a_latch: assert property (p_latch) else $error("latched address wrong"); // [R17]

	property p_ready;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		(low_en && low_hit) |=> (O_WAIT_STATES == $past(lower_area_limit[1:0]))
			&& (O_EXT_READY_USE == !$past(lower_area_limit[2]));
	endproperty
	a_ready: assert property (p_ready) else $error("low ready mode wrong"); // [R5]

	// ------------------------------------------------------------
	// Checks on space, ready source, DMA and reset
	// ------------------------------------------------------------
	sequence s_mid_only_cycle;
		mid_en && mid_hit && !(low_en && low_hit);
	endsequence
	property p_mid_ready;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		s_mid_only_cycle |=> (O_WAIT_STATES == $past(midrange_base_reg[1:0]))
			&& (O_EXT_READY_USE == !$past(midrange_base_reg[2]));
	endproperty
	a_mid_ready: assert property (p_mid_ready) else $error("mid ready mode wrong"); // [R11]

	sequence s_dma_mid_cycle;
		I_CYCLE_DMA && mid_en && mid_hit && (mid_q == 2'h2);
	endsequence
	property p_dma_mid;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		s_dma_mid_cycle |=> !O_MID_RANGE_SELECTS_N[2];
	endproperty
	a_dma_mid: assert property (p_dma_mid) else $error("DMA mid select missed"); // [R23]

	property p_mem_only;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		!I_CYCLE_MEM |=> O_LOW_MEMORY_SELECT_N && (O_MID_RANGE_SELECTS_N == 4'hf);
	endproperty
	a_mem_only: assert property (p_mem_only) else $error("memory select on I/O"); // [R24]

	property p_reset_high;
		@(posedge I_MCLK)
		!I_ARST_N |=> O_LOW_MEMORY_SELECT_N && (O_MID_RANGE_SELECTS_N == 4'hf)
			&& (O_PERIPHERAL_SELECTS_N == 7'h7f);
	endproperty
	a_reset_high: assert property (p_reset_high) else $error("select low in reset"); // [R22]

	property p_per_space;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		(midrange_size_reg[`PER_SPACE_BIT] != I_CYCLE_MEM) && !latch_mode
			|=> (O_PERIPHERAL_SELECTS_N == 7'h7f);
	endproperty
	a_per_space: assert property (p_per_space) else $error("peripheral on wrong space"); // [R18]

	sequence s_per_hi_cycle;
		per_en && per_win[4] && !(low_en && low_hit) && !(mid_en && mid_hit);
	endsequence
	property p_per_hi_ready;
		@(posedge I_MCLK) disable iff (!I_ARST_N)
		s_per_hi_cycle |=> O_AREA_HIT && (O_WAIT_STATES == $past(midrange_size_reg[1:0]));
	endproperty
	a_per_hi_ready: assert property (p_per_hi_ready) else $error("per4 ready wrong"); // [R20]
endmodule
`default_nettype wire

/* File: sim/mem_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none

module mem_periph_model (
	input  wire logic       i_low_n,
	input  wire logic [3:0] i_mid_n,
	input  wire logic [6:0] i_per_n,
	input  wire logic       i_latch,
	output logic      [3:0] o_active
);
	// ----------------------------------------
	// Devices enabled by low selects
	// ----------------------------------------
	logic [3:0] n_main;
	logic [3:0] n_top;
	assign n_main = 4'($countones({~i_low_n, ~i_mid_n, ~i_per_n[4:0]}));
	assign n_top = i_latch ? 4'd0 : 4'($countones(~i_per_n[6:5]));
	assign o_active = n_main + n_top;
endmodule

`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        I_MCLK, I_ARST_N, I_ENHANCED, I_CYCLE, I_CYCLE_MEM, I_CYCLE_DMA;
	logic        I_REG_SEL, I_REG_WR, I_REG_RD, O_LOW_MEMORY_SELECT_N;
	logic        O_AREA_HIT, O_EXT_READY_USE, latch;
	logic [19:0] I_ADDR;
	logic [7:0]  I_REG_OFS;
	logic [15:0] I_REG_WDATA, O_REG_RDATA;
	logic [3:0]  O_MID_RANGE_SELECTS_N, act;
	logic [6:0]  O_PERIPHERAL_SELECTS_N;
	logic [1:0]  O_WAIT_STATES;
	logic [11:0] sel;
	logic [3:0]  rdy;
	int          bad_count = 0;
	int          check_count = 0;

	assign sel = {O_LOW_MEMORY_SELECT_N, O_MID_RANGE_SELECTS_N, O_PERIPHERAL_SELECTS_N};
	assign rdy = {O_AREA_HIT, O_WAIT_STATES, O_EXT_READY_USE};

	lower_mid_periph_chip_select i_lower_mid_periph_chip_select (
		.I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_ENHANCED(I_ENHANCED),
		.I_ADDR(I_ADDR), .I_CYCLE(I_CYCLE), .I_CYCLE_MEM(I_CYCLE_MEM),
		.I_CYCLE_DMA(I_CYCLE_DMA), .I_REG_SEL(I_REG_SEL), .I_REG_WR(I_REG_WR),
		.I_REG_RD(I_REG_RD), .I_REG_OFS(I_REG_OFS), .I_REG_WDATA(I_REG_WDATA),
		.O_REG_RDATA(O_REG_RDATA), .O_LOW_MEMORY_SELECT_N(O_LOW_MEMORY_SELECT_N),
		.O_MID_RANGE_SELECTS_N(O_MID_RANGE_SELECTS_N),
		.O_PERIPHERAL_SELECTS_N(O_PERIPHERAL_SELECTS_N), .O_AREA_HIT(O_AREA_HIT),
		.O_WAIT_STATES(O_WAIT_STATES), .O_EXT_READY_USE(O_EXT_READY_USE));

	mem_periph_model i_mem_periph_model (
		.i_low_n(O_LOW_MEMORY_SELECT_N), .i_mid_n(O_MID_RANGE_SELECTS_N),
		.i_per_n(O_PERIPHERAL_SELECTS_N), .i_latch(latch), .o_active(act));

	// ----------------------------------------
	// Clock, watchdog and verdict
	// ----------------------------------------
	initial begin
		I_MCLK = 0;
		forever #10 I_MCLK = ~I_MCLK;
	end

	initial begin
		#100000;
		bad_count++;
		complete_run();
	end

	task automatic complete_run();
		if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask

	task automatic reg_op(input logic wr, input logic [7:0] ofs, input logic [15:0] d);
		@(posedge I_MCLK);
		#1;
		I_REG_SEL = 1;
		I_REG_WR = wr;
		I_REG_RD = !wr;
		I_REG_OFS = ofs;
		I_REG_WDATA = d;
		@(posedge I_MCLK);
		#1;
		I_REG_SEL = 0;
		I_REG_WR = 0;
		I_REG_RD = 0;
	endtask

	task automatic dec(input logic [19:0] a, input logic m, input logic [11:0] es,
			input logic [3:0] er, input logic cr);
		@(posedge I_MCLK);
		#1;
		I_ADDR = a;
		I_CYCLE_MEM = m;
		I_CYCLE = 1;
		@(posedge I_MCLK);
		#1;
		chk(sel === es, "select pattern");
		if (cr) chk(rdy === er, "ready outputs");
		chk(act <= 4'd1, "overlapping selects");
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		repeat (3) @(posedge I_MCLK);
		#1;
		chk(sel === 12'hfff, "selects during reset");
		I_ARST_N = 1;
		reg_op(1, 8'ha8, 16'h04c4);
		dec(20'h00000, 1, 12'hfff, 4'h0, 1);
	endtask

	task automatic t_low();
		reg_op(1, 8'ha2, 16'h0039);
		dec(20'h00000, 1, 12'h7ff, 4'hb, 1);
		dec(20'h003ff, 1, 12'h7ff, 4'hb, 1);
		dec(20'h00400, 1, 12'hfff, 4'h0, 1);
		dec(20'h003ff, 0, 12'hfff, 4'h0, 1);
		reg_op(0, 8'ha2, 16'h0000);
		chk(O_REG_RDATA === 16'h0039, "limit readback");
		reg_op(0, 8'haa, 16'h0000);
		chk(O_REG_RDATA === 16'h0000, "unmapped read");
	endtask

	task automatic t_mid();
		reg_op(1, 8'ha6, 16'h1006);
		for (int q = 0; q < 4; q++)
			dec(20'h10000 + 20'(q) * 20'h02000, 1, 12'hfff ^ (12'h080 << q), 4'hc, 1);
		dec(20'h18000, 1, 12'hfff, 4'h0, 1);
		dec(20'h10000, 0, 12'hfff, 4'h0, 1);
	endtask

	task automatic t_per();
		reg_op(1, 8'ha4, 16'h0103);
		for (int n = 0; n < 7; n++)
			dec(20'h01000 + 20'(n) * 20'h00080, 1, 12'hfff ^ (12'h001 << n),
				(n < 4) ? 4'hf : 4'h8, 1);
		dec(20'h01380, 1, 12'hfff, 4'h0, 1);
		dec(20'h01000, 0, 12'hfff, 4'h0, 1);
		reg_op(1, 8'ha8, 16'h0484);
		dec(20'h01080, 0, 12'hffd, 4'hf, 1);
		dec(20'h01080, 1, 12'hfff, 4'h0, 1);
	endtask

	task automatic t_latch();
		reg_op(1, 8'ha8, 16'h0404);
		latch = 1;
		I_CYCLE_DMA = 1;
		dec(20'h01004, 0, 12'hfde, 4'hf, 1);
		dec(20'h01002, 0, 12'hfbe, 4'hf, 1);
	endtask

	task automatic t_enh();
		@(posedge I_MCLK);
		#1;
		I_ENHANCED = 1;
		dec(20'h14000, 1, 12'hd9f, 4'hc, 1);
		dec(20'h10000, 1, 12'hf9f, 4'h0, 0);
		dec(20'h16000, 1, 12'hf9f, 4'h0, 0);
	endtask

	initial begin
		I_ARST_N = 0;
		I_ENHANCED = 0;
		I_CYCLE = 0;
		I_CYCLE_MEM = 1;
		I_CYCLE_DMA = 0;
		I_REG_SEL = 0;
		I_REG_WR = 0;
		I_REG_RD = 0;
		I_ADDR = 20'h00000;
		I_REG_OFS = 8'h00;
		I_REG_WDATA = 16'h0000;
		latch = 0;
		t_reset();
		t_low();
		t_mid();
		t_per();
		t_latch();
		t_enh();
		complete_run();
	end
endmodule

`default_nettype wire
